/* rtl/ssr_regs.svh */
// constants for the supply status and range block
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ----------------------------------------------------------------
// operation register bit positions and masks
// ----------------------------------------------------------------
`define SSR_BIT_CURR_REG   10
`define SSR_BIT_VOLT_REG   8
`define SSR_OPER_USED      16'h0521
`define SSR_OPER_MAX       16'h0521
`define SSR_OPER_RESET     16'h0000

// ----------------------------------------------------------------
// argument codes, error and answer formats
// ----------------------------------------------------------------
`define SSR_RANGE_FULL     16'h0001
`define SSR_RANGE_QUARTER  16'h0004
`define SSR_BOOL_ON        16'h0001
`define SSR_BOOL_OFF       16'h0000
`define SSR_ERR_RANGE      (-16'sd222)
`define SSR_EXP_MILLI      (-4'sd3)
`define SSR_EXP_UNITY      4'sd0

`endif

/* rtl/ssr_pkg.sv */
// types shared by the supply status and range block
`default_nettype none

package ssr_pkg;

  // decoded host commands and queries
  typedef enum logic [3:0] {
    SSR_CMD_RST,
    SSR_CMD_VOLT_SET,
    SSR_CMD_VOLT_AUTO,
    SSR_CMD_CURR_AUTO,
    SSR_CMD_VOLT_RANGE,
    SSR_CMD_CURR_RANGE,
    SSR_CMD_RANGE_Q,
    SSR_CMD_TRIG_SET,
    SSR_CMD_TRIG_Q,
    SSR_CMD_TRIGGER,
    SSR_CMD_LIMIT_SET,
    SSR_CMD_COND_Q,
    SSR_CMD_ENAB_SET,
    SSR_CMD_ENAB_Q,
    SSR_CMD_EVENT_Q,
    SSR_CMD_PRESET
  } ssr_cmd_t;

endpackage : ssr_pkg

`default_nettype wire

/* rtl/ssr_status_range.sv */
// settings, range selection and operation status of the supply card
//
// How it works
// - power up and reset enable autoranging
// - auto 0 or explicit range disables autoranging
// - autorange picks full above quarter scale
// - auto argument 1 on, 0 off
// - triggered voltage applied only on trigger
// - triggered value above maximum posts -222
// - triggered value above limit stores limit
// - triggered query returns value with exponent
// - condition register follows live state unlatched
// - bit 10 current mode, bit 8 voltage
// - summary is OR of enabled events
// - mask accepts 0 to 1313, reads back
// - event register read only, latches events
// - event read returns value then clears
// - preset clears condition registers to zero
// - range 1 full, 4 quarter, auto off
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.svh"

module ssr_status_range
  import ssr_pkg::*;
#(
  parameter int          VW         = 16,
  parameter logic [15:0] VOLT_MAX   = 16'h2710,
  parameter logic [15:0] FULL_SCALE = 16'h2710
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          cmd_valid,
  input  wire ssr_cmd_t      cmd_code,
  input  wire logic [VW-1:0] cmd_arg,
  input  wire logic          curr_reg_pin,
  input  wire logic          volt_reg_pin,
  output logic               resp_valid,
  output logic [VW-1:0]      resp_value,
  output logic signed [3:0]  resp_exp,
  output logic               err_valid,
  output logic signed [15:0] err_code,
  output logic               autorange_on,
  output logic               range_full,
  output logic [VW-1:0]      out_volt,
  output logic               ques_cond_clear,
  output logic               oper_summary
);

  if (VW != 16) begin : g_bad_width
    $error("ssr_status_range: VW must be 16");
  end
  if (VOLT_MAX == 16'h0000 || FULL_SCALE < 16'h0004) begin : g_bad_scale
    $error("ssr_status_range: bad scale parameters");
  end

  localparam logic [VW-1:0] QUARTER = FULL_SCALE >> 2;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic is_rst, is_vset, is_auto, is_range, is_tset, is_tq, is_trg;
  logic is_lim, is_condq, is_ensl, is_enq, is_evq, is_pres, is_rq;
  logic arg_on, arg_off, arg_full, arg_quarter;

  always_comb begin
    is_rst   = cmd_valid && cmd_code == SSR_CMD_RST;
    is_vset  = cmd_valid && cmd_code == SSR_CMD_VOLT_SET;
    is_auto  = cmd_valid && (cmd_code == SSR_CMD_VOLT_AUTO || cmd_code == SSR_CMD_CURR_AUTO);
    is_range = cmd_valid && (cmd_code == SSR_CMD_VOLT_RANGE || cmd_code == SSR_CMD_CURR_RANGE);
    is_rq    = cmd_valid && cmd_code == SSR_CMD_RANGE_Q;
    is_tset  = cmd_valid && cmd_code == SSR_CMD_TRIG_SET;
    is_tq    = cmd_valid && cmd_code == SSR_CMD_TRIG_Q;
    is_trg   = cmd_valid && cmd_code == SSR_CMD_TRIGGER;
    is_lim   = cmd_valid && cmd_code == SSR_CMD_LIMIT_SET;
    is_condq = cmd_valid && cmd_code == SSR_CMD_COND_Q;
    is_ensl  = cmd_valid && cmd_code == SSR_CMD_ENAB_SET;
    is_enq   = cmd_valid && cmd_code == SSR_CMD_ENAB_Q;
    is_evq   = cmd_valid && cmd_code == SSR_CMD_EVENT_Q;
    is_pres  = cmd_valid && cmd_code == SSR_CMD_PRESET;
    arg_on      = cmd_arg == `SSR_BOOL_ON;
    arg_off     = cmd_arg == `SSR_BOOL_OFF;
    arg_full    = cmd_arg == `SSR_RANGE_FULL;
    arg_quarter = cmd_arg == `SSR_RANGE_QUARTER;
  end

  // ----------------------------------------------------------------
  // range selection
  // ----------------------------------------------------------------
  logic [VW-1:0] level_r;
  logic [VW-1:0] trig_r;
  logic          trig_over;
  logic          auto_r;
  logic          full_r;

  always_ff @(posedge clk) begin
    if (rst || is_rst) begin
      level_r <= '0;
    end else if (is_vset && !trig_over) begin
      level_r <= cmd_arg;
    end else if (is_trg) begin
      level_r <= trig_r;
    end
  end

  always_ff @(posedge clk) begin
    // on at power up and reset
    if (rst || is_rst) begin
      auto_r <= 1'b1;
    end else if (is_auto && arg_on) begin
      auto_r <= 1'b1;
    end else if ((is_auto && arg_off) || (is_range && (arg_full || arg_quarter))) begin
      auto_r <= 1'b0;
    end
  end

  // values other than 1 and 4 leave the range untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      full_r <= 1'b0;
    end else if (is_range && arg_full) begin
      full_r <= 1'b1;
    end else if (is_range && arg_quarter) begin
      full_r <= 1'b0;
    end else if (auto_r) begin
      full_r <= level_r > QUARTER;
    end
  end

  assign autorange_on = auto_r;
  assign range_full   = full_r;

  // ----------------------------------------------------------------
  // triggered voltage
  // ----------------------------------------------------------------
  logic [VW-1:0] limit_r;
  logic [VW-1:0] out_r;

  assign trig_over = cmd_arg > VOLT_MAX;

  always_ff @(posedge clk) begin
    if (rst) begin
      limit_r <= VOLT_MAX;
    end else if (is_lim && !trig_over) begin
      limit_r <= cmd_arg;
    end
  end

  // out of range value is refused, stored value kept
  always_ff @(posedge clk) begin
    if (rst || is_rst) begin
      trig_r <= '0;
    end else if (is_tset && !trig_over) begin
      trig_r <= (cmd_arg > limit_r) ? limit_r : cmd_arg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || is_rst) begin
      out_r <= '0;
    end else if (is_vset && !trig_over) begin
      out_r <= cmd_arg;
    end else if (is_trg) begin
      out_r <= trig_r;
    end
  end

  assign out_volt = out_r;

  // ----------------------------------------------------------------
  // operation status group
  // ----------------------------------------------------------------
  logic [1:0]  pin_s1_r;
  logic [1:0]  pin_s2_r;
  logic [1:0]  pin_prev_r;
  logic [15:0] cond_r;
  logic [15:0] mask_r;
  logic [15:0] event_r;
  logic [15:0] rise;
  logic [15:0] cond_prev_r;
  logic        summ_r;

  // pins are asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
    end else begin
      pin_s1_r <= {curr_reg_pin, volt_reg_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  // preset zeroes the register until the live state next changes
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_r <= 2'h0;
      cond_r     <= `SSR_OPER_RESET;
    end else begin
      pin_prev_r <= pin_s2_r;
      if (is_pres) begin
        cond_r <= `SSR_OPER_RESET;
      end else if (pin_s2_r != pin_prev_r) begin
        cond_r <= `SSR_OPER_RESET;
        cond_r[`SSR_BIT_CURR_REG] <= pin_s2_r[1];
        cond_r[`SSR_BIT_VOLT_REG] <= pin_s2_r[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cond_prev_r <= `SSR_OPER_RESET;
    end else begin
      cond_prev_r <= cond_r;
    end
  end

  assign rise = cond_r & ~cond_prev_r & `SSR_OPER_USED;

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= `SSR_OPER_RESET;
    end else if (is_ensl && cmd_arg <= `SSR_OPER_MAX) begin
      mask_r <= cmd_arg;
    end
  end

  // an edge in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      event_r <= `SSR_OPER_RESET;
    end else if (is_evq) begin
      event_r <= rise;
    end else begin
      event_r <= event_r | rise;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      summ_r <= 1'b0;
    end else begin
      summ_r <= |(event_r & mask_r);
    end
  end

  assign oper_summary    = summ_r;
  assign ques_cond_clear = is_pres;

  // ----------------------------------------------------------------
  // answers and errors
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_value <= '0;
      resp_exp   <= `SSR_EXP_UNITY;
    end else begin
      resp_valid <= is_rq || is_tq || is_condq || is_enq || is_evq;
      resp_exp   <= `SSR_EXP_UNITY;
      if (is_rq) begin
        resp_value <= full_r ? `SSR_RANGE_FULL : `SSR_RANGE_QUARTER;
      end else if (is_tq) begin
        resp_value <= trig_r;
        resp_exp   <= `SSR_EXP_MILLI;
      end else if (is_condq) begin
        resp_value <= cond_r;
      end else if (is_enq) begin
        resp_value <= mask_r;
      end else if (is_evq) begin
        resp_value <= event_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      err_valid <= 1'b0;
      err_code  <= 16'sh0000;
    end else if (((is_tset || is_lim || is_vset) && trig_over) ||
                 (is_ensl && cmd_arg > `SSR_OPER_MAX)) begin
      err_valid <= 1'b1;
      err_code  <= `SSR_ERR_RANGE;
    end else begin
      err_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rst_auto_on_a: assert property (is_rst |=> auto_r)
    else $error("autorange not on after reset command");
  auto_off_a: assert property ((is_auto && arg_off) || (is_range && arg_quarter) |=> !auto_r)
    else $error("autorange not turned off");
  auto_select_a: assert property (auto_r && !is_range ##1 auto_r && !is_range |=>
      full_r == ($past(level_r) > QUARTER))
    else $error("autorange picked wrong range");
  range_cmd_a: assert property (is_range && arg_full |=> full_r && !auto_r)
    else $error("range 1 not applied");
  out_hold_a: assert property (!(is_trg || is_rst || is_vset) |=> $stable(out_r))
    else $error("output moved without trigger");
  trig_apply_a: assert property (is_trg |=> out_r == $past(trig_r))
    else $error("trigger did not apply stored value");
  over_err_a: assert property (is_tset && trig_over |=> err_valid && err_code == -16'sd222
      && $stable(trig_r))
    else $error("over maximum not reported");
  trig_clamp_a: assert property (is_tset && !trig_over && cmd_arg > limit_r |=>
      trig_r == $past(limit_r))
    else $error("triggered value not clamped");
  trig_query_a: assert property (is_tq |=> resp_valid && resp_value == $past(trig_r)
      && resp_exp == -4'sd3)
    else $error("triggered query wrong");
  preset_clr_a: assert property (is_pres |=> cond_r == 16'h0000)
    else $error("preset left condition bits");
  mask_back_a: assert property (is_ensl && cmd_arg <= 16'h0521 ##1 !is_ensl ##1 is_enq |=>
      resp_value == $past(cmd_arg, 3))
    else $error("mask readback differs");
  event_read_a: assert property (is_evq |=> resp_value == $past(event_r)
      && event_r == $past(rise))
    else $error("event read did not clear");
  event_latch_a: assert property (rise[`SSR_BIT_CURR_REG] ##1 !is_evq [*3] |->
      event_r[`SSR_BIT_CURR_REG])
    else $error("event not held");
  summary_a: assert property (##1 summ_r == |($past(event_r) & $past(mask_r)))
    else $error("summary mismatch");
  cond_bits_a: assert property ((cond_r & ~16'h0500) == 16'h0000)
    else $error("unused condition bit set");

  mode_change_c: cover property (rise[`SSR_BIT_VOLT_REG] ##[1:20] is_evq);
  trig_flow_c: cover property (is_tset ##[1:8] is_trg ##[1:4] is_rq);
  summary_c: cover property (is_ensl ##[1:20] summ_r);
  auto_flip_c: cover property (auto_r && !full_r ##[1:20] auto_r && full_r);

endmodule : ssr_status_range

`default_nettype wire

/* bench/ssr_host_model.sv */
// host side model issuing decoded commands to the block
`timescale 1ns/1ps
`default_nettype none

module ssr_host_model
  import ssr_pkg::*;
(
  input  wire logic        clk,
  output var  logic        cmd_valid,
  output var  ssr_cmd_t    cmd_code,
  output var  logic [15:0] cmd_arg
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = SSR_CMD_RANGE_Q;
    cmd_arg   = 16'h0000;
  end

  // any argument is driven as given, nothing is checked
  // booleans stay 0/1 and masks within 1313 unless a refusal is wanted
  task automatic put(input ssr_cmd_t c, input logic [15:0] a);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_arg   = a;
  endtask

  // stale argument inverted so it never passes for fresh data
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_arg   = ~cmd_arg;
  endtask

  // one command: driven after an edge, taken at the next, then released
  task automatic send(input ssr_cmd_t c, input logic [15:0] a);
    @(posedge clk);
    #1 put(c, a);
    @(posedge clk);
    #1 idle();
  endtask
endmodule // ssr_host_model

`default_nettype wire

/* bench/ssr_status_range_tb.sv */
// self-checking testbench for the supply status and range block
`timescale 1ns/1ps
`default_nettype none

module ssr_status_range_tb import ssr_pkg::*;;
  typedef struct packed {ssr_cmd_t c; logic [15:0] a; logic [15:0] v; logic au;} ssr_row_t;

  logic               clk, rst, cmd_valid, curr_reg_pin, volt_reg_pin;
  logic               resp_valid, err_valid, autorange_on, range_full;
  logic               ques_cond_clear, oper_summary;
  ssr_cmd_t           cmd_code;
  logic [15:0]        cmd_arg, resp_value, out_volt;
  logic signed [3:0]  resp_exp;
  logic signed [15:0] err_code;
  int                 n_fail, check_count;

  // ----------------------------------------
  // ordinary cases: command, argument, answer, autorange
  // ----------------------------------------
  ssr_row_t rows [25] = '{
    '{SSR_CMD_ENAB_SET, 16'h0521, 16'h0000, 1'b1}, '{SSR_CMD_ENAB_Q, 16'h0000, 16'h0521, 1'b1},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0004, 1'b1}, '{SSR_CMD_VOLT_SET, 16'h09c4, 16'h0000, 1'b1},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0004, 1'b1}, '{SSR_CMD_VOLT_SET, 16'h09c5, 16'h0000, 1'b1},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0001, 1'b1}, '{SSR_CMD_VOLT_RANGE, 16'h0004, 16'h0000, 1'b0},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0004, 1'b0}, '{SSR_CMD_CURR_AUTO, 16'h0001, 16'h0000, 1'b1},
    '{SSR_CMD_CURR_RANGE, 16'h0004, 16'h0000, 1'b0}, '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0004, 1'b0},
    '{SSR_CMD_VOLT_AUTO, 16'h0001, 16'h0000, 1'b1}, '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0001, 1'b1},
    '{SSR_CMD_VOLT_AUTO, 16'h0000, 16'h0000, 1'b0}, '{SSR_CMD_VOLT_SET, 16'h03e8, 16'h0000, 1'b0},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0001, 1'b0}, '{SSR_CMD_CURR_AUTO, 16'h0001, 16'h0000, 1'b1},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0004, 1'b1}, '{SSR_CMD_VOLT_RANGE, 16'h0001, 16'h0000, 1'b0},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0001, 1'b0}, '{SSR_CMD_CURR_AUTO, 16'h0000, 16'h0000, 1'b0},
    '{SSR_CMD_VOLT_AUTO, 16'h0001, 16'h0000, 1'b1}, '{SSR_CMD_VOLT_RANGE, 16'h0002, 16'h0000, 1'b1},
    '{SSR_CMD_RANGE_Q, 16'h0000, 16'h0004, 1'b1}
  };

  ssr_status_range dut_u (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .curr_reg_pin(curr_reg_pin), .volt_reg_pin(volt_reg_pin), .resp_valid(resp_valid),
    .resp_value(resp_value), .resp_exp(resp_exp), .err_valid(err_valid), .err_code(err_code),
    .autorange_on(autorange_on), .range_full(range_full), .out_volt(out_volt),
    .ques_cond_clear(ques_cond_clear), .oper_summary(oper_summary)
  );

  ssr_host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic isq(ssr_cmd_t c);
    return c inside {SSR_CMD_RANGE_Q, SSR_CMD_TRIG_Q, SSR_CMD_COND_Q, SSR_CMD_ENAB_Q, SSR_CMD_EVENT_Q};
  endfunction

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic q(input ssr_cmd_t c, input logic [15:0] exp, input string what);
    host_u.send(c, 16'h0000);
    chk_val(resp_value, exp, what);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // whole run is about 120 cycles; 5000 means a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    curr_reg_pin = 1'b0;
    volt_reg_pin = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    chk_bit(autorange_on, 1'b1, "auto at reset");
    chk_bit(range_full, 1'b0, "range at reset");
    chk_bit(oper_summary, 1'b0, "summary at reset");
    foreach (rows[i]) begin
      host_u.send(rows[i].c, rows[i].a);
      chk_bit(resp_valid, isq(rows[i].c), "answer pulse");
      if (isq(rows[i].c)) chk_val(resp_value, rows[i].v, "answer");
      chk_bit(autorange_on, rows[i].au, "autorange");
    end
    // ----------------------------------------
    // triggered value, clamp and errors
    // ----------------------------------------
    host_u.send(SSR_CMD_LIMIT_SET, 16'h0bb8);
    host_u.send(SSR_CMD_TRIG_SET, 16'h0fa0);
    chk_val(out_volt, 16'h03e8, "out before trigger");
    q(SSR_CMD_TRIG_Q, 16'h0bb8, "clamped value");
    chk_val({12'h000, resp_exp}, 16'h000d, "exponent");
    host_u.send(SSR_CMD_TRIGGER, 16'h0000);
    chk_val(out_volt, 16'h0bb8, "out after trigger");
    q(SSR_CMD_RANGE_Q, 16'h0001, "range follows trigger");
    host_u.send(SSR_CMD_TRIG_SET, 16'h2711);
    chk_bit(err_valid, 1'b1, "error pulse");
    chk_val(err_code, 16'hff22, "error code");
    q(SSR_CMD_TRIG_Q, 16'h0bb8, "value kept");
    host_u.send(SSR_CMD_VOLT_SET, 16'h2711);
    chk_bit(err_valid, 1'b1, "setting over maximum");
    chk_val(out_volt, 16'h0bb8, "setting refused");
    host_u.send(SSR_CMD_ENAB_SET, 16'h0522);
    chk_bit(err_valid, 1'b1, "mask refused");
    q(SSR_CMD_ENAB_Q, 16'h0521, "mask kept");
    // ----------------------------------------
    // live, latched and summary status
    // ----------------------------------------
    volt_reg_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk_bit(oper_summary, 1'b1, "summary set");
    q(SSR_CMD_COND_Q, 16'h0100, "voltage mode");
    q(SSR_CMD_EVENT_Q, 16'h0100, "event latched");
    q(SSR_CMD_EVENT_Q, 16'h0000, "event cleared");
    chk_bit(oper_summary, 1'b0, "summary clear");
    volt_reg_pin = 1'b0;
    curr_reg_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk_bit(oper_summary, 1'b1, "summary current");
    host_u.send(SSR_CMD_ENAB_SET, 16'h0100);
    @(posedge clk);
    #1 chk_bit(oper_summary, 1'b0, "masked off");
    q(SSR_CMD_COND_Q, 16'h0400, "current mode");
    q(SSR_CMD_EVENT_Q, 16'h0400, "current event");
    @(posedge clk);
    #1 host_u.put(SSR_CMD_PRESET, 16'h0000);
    #2 chk_bit(ques_cond_clear, 1'b1, "preset pulse");
    @(posedge clk);
    #1 host_u.idle();
    q(SSR_CMD_COND_Q, 16'h0000, "preset clears");
    // ----------------------------------------
    // reset command and a second hard reset
    // ----------------------------------------
    host_u.send(SSR_CMD_VOLT_AUTO, 16'h0000);
    host_u.send(SSR_CMD_RST, 16'h0000);
    chk_bit(autorange_on, 1'b1, "auto on reset cmd");
    host_u.send(SSR_CMD_VOLT_AUTO, 16'h0000);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk_bit(autorange_on, 1'b1, "auto on power up");
    q(SSR_CMD_EVENT_Q, 16'h0000, "events after reset");
    finish_test();
  end
endmodule // ssr_status_range_tb

`default_nettype wire
